// ### core/ectm_params.svh
`ifndef ECTM_PARAMS_SVH
`define ECTM_PARAMS_SVH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define ECTM_IDX_TIMER_CTRL  6'h00
`define ECTM_IDX_COMMON      6'h01
`define ECTM_IDX_LOW_RELOAD  6'h04
`define ECTM_IDX_HIGH_RELOAD 6'h05
`define ECTM_IDX_LOW_CAP     6'h0A
`define ECTM_IDX_HIGH_CAP    6'h0B
`define ECTM_IDX_COUNT       6'h0C
`define ECTM_IDX_PORT_DATA   6'h10

// ************************************************************
// eight_bit_timer_control fields
// ************************************************************
`define ECTM_TC_EN       7
`define ECTM_TC_ONESHOT  6
`define ECTM_TC_TO_STS   5
`define ECTM_TC_CAP_STS  4
`define ECTM_TC_CAP_IE   2
`define ECTM_TC_TO_IE    1
`define ECTM_TC_AUX_SEL  0
`define ECTM_TC_WMASK    8'hC7

// ************************************************************
// common_function_control fields
// ************************************************************
`define ECTM_CF_MODE     7
`define ECTM_CF_SRC      6
`define ECTM_CF_SEL_HI   5
`define ECTM_CF_SEL_LO   4
`define ECTM_CF_INIT     1
`define ECTM_CF_WMASK    8'hF2

// ************************************************************
// reset values and timing
// ************************************************************
`define ECTM_TC_RST      8'h00
`define ECTM_CF_RST      8'h00
`define ECTM_RELOAD_RST  8'h00
`define ECTM_CAP_RST     8'h00
`define ECTM_PD_RST      2'h0
`define ECTM_TICK_DIV    8'h04

`endif

// ### core/ectm_pkg.sv
package ectm_pkg;

  // ************************************************************
  // timer sequencer states, gray along idle -> wait -> run
  // ************************************************************
  typedef enum logic [1:0] {
    ECTM_IDLE = 2'b00,
    ECTM_WAIT = 2'b01,
    ECTM_RUN  = 2'b11
  } ectm_state_t;

  // ************************************************************
  // state of the pin synchroniser
  // ************************************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ectm_sync_t;

  // ************************************************************
  // state of the timer core
  // ************************************************************
  typedef struct packed {
    logic [7:0]  tc;
    logic [7:0]  common;
    logic [7:0]  low_rel;
    logic [7:0]  high_rel;
    logic [7:0]  low_cap;
    logic [7:0]  high_cap;
    logic [7:0]  cnt;
    logic [1:0]  pd;
    ectm_state_t st;
    logic        out;
    logic        first;
    logic [7:0]  div;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        aux_pin;
    logic        route_pin;
    logic        to_irq;
    logic        cap_irq;
  } ectm_core_t;

endpackage : ectm_pkg

// ### core/ectm_pin_sync.sv
`timescale 1ns/1ps
module ectm_pin_sync
  import ectm_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous pin
  input  wire logic pin,
  // edge pulses on pclk
  output logic      rise,
  output logic      fall
);

  ectm_sync_t q;
  ectm_sync_t d;

  // ************************************************************
  // two-flop synchroniser plus one flop for edge history
  // ************************************************************
  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // edges come only from the settled flops, never from s1
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;

endmodule : ectm_pin_sync

// ### core/ectm_timer_top.sv
`timescale 1ns/1ps
`include "ectm_params.svh"
// Behaviour
// - capture stores raise capture interrupt when its enable is set
// - timeout raises timeout interrupt when its enable is set
// - aux select puts port data or counter output on port3 line4
// - common bit 7 picks transmit (0, default) or demodulation (1)
// - common bit 6 routes line6 output, or picks demod input pin
// - bits 5:4 pick output combine logic or demod edge polarity
// - on enable, output takes initial bit; low or high reload loads
// - one-shot counts to zero, stops, toggles, sets timeout status
// - continuous toggles each terminal; first raises nothing; reloads by output
// - reload writes accepted any time, used at next load
// - initial count zero wraps to FF and keeps counting down
// - the zero to FF wrap is no timeout
// - demod waits for first qualifying edge before counting
// - later qualifying edges capture the complemented count
module ectm_timer_top
  import ectm_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // demodulation input pins
  input  wire logic        port3_line1,
  input  wire logic        port2_line0,
  // output of the sixteen-bit counter, same clock
  input  wire logic        sixteen_bit_counter_out,
  // output pins and interrupts
  output logic             port3_line4,
  output logic             port3_line6,
  output logic             timeout_irq,
  output logic             capture_irq
);

  localparam ectm_core_t CORE_RST = '{
    tc:        `ECTM_TC_RST,     common:    `ECTM_CF_RST,
    low_rel:   `ECTM_RELOAD_RST, high_rel:  `ECTM_RELOAD_RST,
    low_cap:   `ECTM_CAP_RST,    high_cap:  `ECTM_CAP_RST,
    cnt:       8'h00,            pd:        `ECTM_PD_RST,
    st:        ECTM_IDLE,        out:       1'b0,
    first:     1'b0,             div:       8'h00,
    prdata:    32'h0000_0000,    pready:    1'b0,
    pslverr:   1'b0,             aux_pin:   1'b0,
    route_pin: 1'b0,             to_irq:    1'b0,
    cap_irq:   1'b0
  };

  // ************************************************************
  // helper functions
  // ************************************************************
  function automatic logic [7:0] reload_pick(input logic lvl, input logic [7:0] lo,
                                             input logic [7:0] hi);
    return lvl ? hi : lo;
  endfunction : reload_pick
  function automatic logic combine(input logic a, input logic b, input logic [1:0] sel);
    case (sel)
      2'b00:   return a & b;
      2'b01:   return a | b;
      2'b10:   return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction : combine
  function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
    case (sel)
      2'b00:   return f;
      2'b01:   return r;
      2'b10:   return r | f;
      default: return 1'b0;
    endcase
  endfunction : edge_hit
  function automatic logic idx_ok(input logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    return (a[1:0] == 2'b00) &&
           (i == `ECTM_IDX_TIMER_CTRL || i == `ECTM_IDX_COMMON ||
            i == `ECTM_IDX_LOW_RELOAD || i == `ECTM_IDX_HIGH_RELOAD ||
            i == `ECTM_IDX_LOW_CAP || i == `ECTM_IDX_HIGH_CAP ||
            i == `ECTM_IDX_COUNT || i == `ECTM_IDX_PORT_DATA);
  endfunction : idx_ok

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic line1_rise;
  logic line1_fall;
  logic line0_rise;
  logic line0_fall;

  ectm_pin_sync u_sync_line1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (port3_line1),
    .rise    (line1_rise),
    .fall    (line1_fall)
  );

  ectm_pin_sync u_sync_line0 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (port2_line0),
    .rise    (line0_rise),
    .fall    (line0_fall)
  );

  // ************************************************************
  // core state and next-state logic
  // ************************************************************
  ectm_core_t q;
  ectm_core_t d;
  logic       tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       qual;
  logic       term_ev;
  logic       to_ev;
  logic       cap_ev;
  logic       apb_setup;
  logic       apb_wr;
  logic [7:0] rd;
  logic       demod;

  always_comb begin
    d        = q;
    tick     = 1'b0;
    term_ev  = 1'b0;
    to_ev    = 1'b0;
    cap_ev   = 1'b0;
    rd       = 8'h00;
    demod    = q.common[`ECTM_CF_MODE];
    // demod source pin and polarity select
    pin_rise = q.common[`ECTM_CF_SRC] ? line0_rise : line1_rise;
    pin_fall = q.common[`ECTM_CF_SRC] ? line0_fall : line1_fall;
    qual     = edge_hit(pin_rise, pin_fall,
                        q.common[`ECTM_CF_SEL_HI:`ECTM_CF_SEL_LO]);
    apb_setup = psel & ~penable;
    apb_wr    = psel & penable & q.pready & pwrite & ~q.pslverr;

    // counter clock enable; restarts with each enable so the first tick is a full period
    if (q.st == ECTM_IDLE || q.div == `ECTM_TICK_DIV - 8'h01) begin
      d.div = 8'h00;
      tick  = (q.st != ECTM_IDLE);
    end else begin
      d.div = q.div + 8'h01;
    end

    // sequencer; clearing enable stops it on the next edge
    if (!q.tc[`ECTM_TC_EN]) begin
      d.st = ECTM_IDLE;
    end else begin
      unique case (q.st)
        ECTM_IDLE: begin
          d.out   = q.common[`ECTM_CF_INIT];
          d.cnt   = reload_pick(q.common[`ECTM_CF_INIT], q.low_rel, q.high_rel);
          d.first = 1'b1;
          d.st    = demod ? ECTM_WAIT : ECTM_RUN;
        end
        ECTM_WAIT: begin
          if (qual) begin
            d.st = ECTM_RUN;
          end
        end
        ECTM_RUN: begin
          if (demod) begin
            if (qual) begin
              cap_ev = 1'b1;
              if (pin_rise) begin
                d.high_cap = ~q.cnt;
              end else begin
                d.low_cap = ~q.cnt;
              end
            end
            if (tick) begin
              d.cnt = q.cnt - 8'h01;
            end
          end else if (tick) begin
            if (q.cnt == 8'h01) begin
              // stepping 1 -> 0 is the terminal count
              term_ev = 1'b1;
              d.out   = ~q.out;
              if (q.tc[`ECTM_TC_ONESHOT]) begin
                d.cnt              = 8'h00;
                d.st               = ECTM_IDLE;
                d.tc[`ECTM_TC_EN]  = 1'b0;
                to_ev              = 1'b1;
              end else begin
                d.cnt   = reload_pick(~q.out, q.low_rel, q.high_rel);
                d.first = 1'b0;
                to_ev   = ~q.first;
              end
            end else begin
              // zero wraps to FF here and is not a timeout
              d.cnt = q.cnt - 8'h01;
            end
          end
        end
        default: d.st = ECTM_IDLE;
      endcase
    end

    // register writes; reloads only reach the counter at its next load
    if (apb_wr) begin
      unique case (paddr[7:2])
        `ECTM_IDX_TIMER_CTRL: begin
          d.tc = (pwdata[7:0] & `ECTM_TC_WMASK) |
                 (q.tc & ~pwdata[7:0] & ~`ECTM_TC_WMASK);
        end
        `ECTM_IDX_COMMON:      d.common   = pwdata[7:0] & `ECTM_CF_WMASK;
        `ECTM_IDX_LOW_RELOAD:  d.low_rel  = pwdata[7:0];
        `ECTM_IDX_HIGH_RELOAD: d.high_rel = pwdata[7:0];
        `ECTM_IDX_PORT_DATA:   d.pd       = pwdata[1:0];
        default: ;
      endcase
    end

    // status bits: hardware set beats a same-cycle software clear
    if (to_ev) begin
      d.tc[`ECTM_TC_TO_STS] = 1'b1;
    end
    if (cap_ev) begin
      d.tc[`ECTM_TC_CAP_STS] = 1'b1;
    end

    // interrupt and pin outputs, registered
    d.to_irq  = d.tc[`ECTM_TC_TO_STS] & d.tc[`ECTM_TC_TO_IE];
    d.cap_irq = d.tc[`ECTM_TC_CAP_STS] & d.tc[`ECTM_TC_CAP_IE];
    d.aux_pin   = d.tc[`ECTM_TC_AUX_SEL] ? d.out : d.pd[0];
    d.route_pin = (d.common[`ECTM_CF_SRC] & ~d.common[`ECTM_CF_MODE]) ?
                combine(d.out, sixteen_bit_counter_out,
                        d.common[`ECTM_CF_SEL_HI:`ECTM_CF_SEL_LO]) : d.pd[1];

    // apb: read data is sampled in setup so the access phase needs no wait state
    unique case (paddr[7:2])
      `ECTM_IDX_TIMER_CTRL:  rd = q.tc;
      `ECTM_IDX_COMMON:      rd = q.common;
      `ECTM_IDX_LOW_RELOAD:  rd = q.low_rel;
      `ECTM_IDX_HIGH_RELOAD: rd = q.high_rel;
      `ECTM_IDX_LOW_CAP:     rd = q.low_cap;
      `ECTM_IDX_HIGH_CAP:    rd = q.high_cap;
      `ECTM_IDX_COUNT:       rd = q.cnt;
      `ECTM_IDX_PORT_DATA:   rd = {6'h00, q.pd};
      default:               rd = 8'h00;
    endcase
    d.pready  = apb_setup;
    d.pslverr = apb_setup & ~idx_ok(paddr);
    if (apb_setup) begin
      d.prdata = idx_ok(paddr) ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

  // all control state starts at its default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign port3_line4 = q.aux_pin;
  assign port3_line6 = q.route_pin;
  assign timeout_irq = q.to_irq;
  assign capture_irq = q.cap_irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cap_irq;
    cap_ev && q.tc[`ECTM_TC_CAP_IE] && !apb_wr |=> capture_irq && q.tc[`ECTM_TC_CAP_STS];
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture did not interrupt");
  property p_to_irq;
    to_ev && q.tc[`ECTM_TC_TO_IE] && !apb_wr |=> timeout_irq ##1 timeout_irq;
  endproperty
  a_to_irq: assert property (p_to_irq) else $error("timeout did not interrupt");
  property p_aux;
    port3_line4 == (q.tc[`ECTM_TC_AUX_SEL] ? q.out : q.pd[0]);
  endproperty
  a_aux: assert property (p_aux) else $error("line4 source wrong");
  property p_start;
    q.st == ECTM_IDLE && q.tc[`ECTM_TC_EN] |=> q.out == $past(q.common[`ECTM_CF_INIT]) &&
      q.cnt == $past(q.common[`ECTM_CF_INIT] ? q.high_rel : q.low_rel);
  endproperty
  a_start: assert property (p_start) else $error("start load wrong");
  property p_oneshot;
    term_ev && q.tc[`ECTM_TC_ONESHOT] |=> q.st == ECTM_IDLE && q.cnt == 8'h00 &&
      q.tc[`ECTM_TC_TO_STS] && q.out != $past(q.out);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot end wrong");
  property p_first_quiet;
    term_ev && !q.tc[`ECTM_TC_ONESHOT] && q.first && !q.tc[`ECTM_TC_TO_STS] && !apb_wr
      |=> !q.tc[`ECTM_TC_TO_STS] && !q.first;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("first terminal flagged");
  property p_wrap;
    tick && q.st == ECTM_RUN && !demod && q.tc[`ECTM_TC_EN] && q.cnt == 8'h00
      |-> !to_ev ##1 q.cnt == 8'hFF;
  endproperty
  a_wrap: assert property (p_wrap) else $error("zero wrap wrong");
  property p_wait_hold;
    q.st == ECTM_WAIT && q.tc[`ECTM_TC_EN] && !qual |=> q.st == ECTM_WAIT && $stable(q.cnt);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("counted before first edge");
  property p_capture;
    cap_ev && pin_rise |=> q.high_cap == ~$past(q.cnt) && $stable(q.low_cap);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");
  property p_dec;
    tick && q.st == ECTM_RUN && q.tc[`ECTM_TC_EN] && q.cnt != 8'h01
      |=> q.cnt == $past(q.cnt) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("count step wrong");

endmodule : ectm_timer_top

// ### dv/ectm_ir_partner.sv
`timescale 1ns/1ps
// ************************************************************
// far side: ir receiver pins and sixteen-bit counter output
// ************************************************************
module ectm_ir_partner (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // commands from the bench
  input  wire logic pin_lvl,
  input  wire logic pin_src,
  input  wire logic s16_lvl,
  // lines toward the timer
  output logic      port3_line1,
  output logic      port2_line0,
  output logic      sixteen_bit_counter_out
);
  logic noise_q;

  // unselected pin toggles every cycle, so a wrong source pick floods the captures
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_q                 <= 1'b0;
      sixteen_bit_counter_out <= 1'b0;
    end else begin
      noise_q                 <= ~noise_q;
      sixteen_bit_counter_out <= s16_lvl;
    end
  end

  // selected pin carries the commanded receiver level
  assign port3_line1 = pin_src ? noise_q : pin_lvl;
  assign port2_line0 = pin_src ? pin_lvl : noise_q;
endmodule : ectm_ir_partner

// ### dv/tb_top.sv
`timescale 1ns/1ps
`include "ectm_params.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, lo, hi;
  logic [31:0] pwdata, prdata, rd;
  logic        port3_line1, port2_line0, s16_out, port3_line4, port3_line6;
  logic        timeout_irq, capture_irq, pin_lvl, pin_src, s16_lvl, init;
  integer      seed = 88;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n;
  logic [5:0]  regs [7] = '{`ECTM_IDX_TIMER_CTRL, `ECTM_IDX_COMMON, `ECTM_IDX_LOW_RELOAD,
    `ECTM_IDX_HIGH_RELOAD, `ECTM_IDX_LOW_CAP, `ECTM_IDX_HIGH_CAP, `ECTM_IDX_COUNT};

  ectm_timer_top ectm_timer_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port3_line1(port3_line1),
    .port2_line0(port2_line0), .sixteen_bit_counter_out(s16_out),
    .port3_line4(port3_line4), .port3_line6(port3_line6), .timeout_irq(timeout_irq),
    .capture_irq(capture_irq));
  ectm_ir_partner ectm_ir_partner_i (.pclk(pclk), .presetn(presetn), .pin_lvl(pin_lvl),
    .pin_src(pin_src), .s16_lvl(s16_lvl), .port3_line1(port3_line1),
    .port2_line0(port2_line0), .sixteen_bit_counter_out(s16_out));

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic comb(input logic [1:0] c, input logic a, input logic b);
    case (c)
      2'h0: return a & b;
      2'h1: return a | b;
      2'h2: return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction : comb

  // a terminal count lands from a tick below to 5 cycles above 4 cycles per count
  function automatic logic in_win(input int c, input int ticks);
    return (c >= 4 * ticks - 4) && (c <= 4 * ticks + 5);
  endfunction : in_win

  function automatic logic near(input logic [7:0] v, input int t);
    return (int'(v) >= t - 1) && (int'(v) <= t + 1);
  endfunction : near

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one idle cycle before each setup keeps every signal single-assigned per step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [31:0] rv, output logic ev);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      n_fail++;
      report_and_stop();
    end
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, rd, err);
    `CHK(rd, {24'h000000, e})
  endtask : rchk

  // which: 0 line4, 1 timeout irq, 2 capture irq
  task automatic wait_for(input int which, input logic v, input int lim, output int c);
    logic s;
    for (c = 1; c <= lim; c++) begin
      @(posedge pclk);
      case (which)
        0: s = port3_line4;
        1: s = timeout_irq;
        default: s = capture_irq;
      endcase
      if (s === v) return;
    end
    n_fail++;
    report_and_stop();
  endtask : wait_for

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, pin_lvl, pin_src, s16_lvl} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    apb(1'b0, 6'h3F, 8'h00, rd, err);
    `CHK(err, 1'b1)
    wr(`ECTM_IDX_COMMON, 8'hFF);
    rchk(`ECTM_IDX_COMMON, 8'hF2);
    // plain port data on both lines
    wr(`ECTM_IDX_COMMON, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`ECTM_IDX_PORT_DATA, 8'(k));
      repeat (3) @(posedge pclk);
      `CHK(port3_line4, 1'(k))
      `CHK(port3_line6, 1'(k >> 1))
    end
    // every combine code against both counter levels
    wr(`ECTM_IDX_LOW_RELOAD, 8'hFF);
    wr(`ECTM_IDX_HIGH_RELOAD, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      wr(`ECTM_IDX_COMMON, {6'h10, 1'(i), 1'b0});
      wr(`ECTM_IDX_TIMER_CTRL, 8'h81);
      for (int c = 0; c < 4; c++) begin
        wr(`ECTM_IDX_COMMON, {2'b01, 2'(c), 2'b00, 1'(i), 1'b0});
        for (int s = 0; s < 2; s++) begin
          s16_lvl <= 1'(s);
          repeat (4) @(posedge pclk);
          `CHK(port3_line6, comb(2'(c), 1'(i), 1'(s)))
          `CHK(port3_line4, 1'(i))
        end
      end
      wr(`ECTM_IDX_TIMER_CTRL, 8'h00);
    end
    // one-shot runs with random reloads, never a count of one
    repeat (4) begin
      lo   = 8'(2 + {$random(seed)} % 14);
      hi   = 8'(2 + {$random(seed)} % 14);
      init = 1'($random(seed));
      wr(`ECTM_IDX_LOW_RELOAD, lo);
      wr(`ECTM_IDX_HIGH_RELOAD, hi);
      wr(`ECTM_IDX_COMMON, {6'h00, init, 1'b0});
      wr(`ECTM_IDX_TIMER_CTRL, 8'hC3);
      repeat (3) @(posedge pclk);
      `CHK(port3_line4, init)
      wait_for(1, 1'b1, 80, n);
      `CHK(in_win(n + 3, init ? int'(hi) : int'(lo)), 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(port3_line4, ~init)
      rchk(`ECTM_IDX_TIMER_CTRL, 8'h63);
      rchk(`ECTM_IDX_COUNT, 8'h00);
      wr(`ECTM_IDX_TIMER_CTRL, 8'h20);
      repeat (2) @(posedge pclk);
      `CHK(timeout_irq, 1'b0)
    end
    // continuous: low 4, high 7, low rewritten to 6 while high counts
    wr(`ECTM_IDX_LOW_RELOAD, 8'h04);
    wr(`ECTM_IDX_HIGH_RELOAD, 8'h07);
    wr(`ECTM_IDX_COMMON, 8'h00);
    wr(`ECTM_IDX_TIMER_CTRL, 8'h83);
    // two cycles on, the start load has landed and line4 shows the initial level 0
    repeat (2) @(posedge pclk);
    `CHK(port3_line4, 1'b0)
    wait_for(0, 1'b1, 40, n);
    `CHK(in_win(n, 4), 1'b1)
    `CHK(timeout_irq, 1'b0)
    wr(`ECTM_IDX_LOW_RELOAD, 8'h06);
    wait_for(1, 1'b1, 60, n);
    `CHK(in_win(n + 3, 7), 1'b1)
    repeat (2) @(posedge pclk);
    `CHK(port3_line4, 1'b0)
    wait_for(0, 1'b1, 60, n);
    `CHK(in_win(n + 2, 6), 1'b1)
    // stop first, clear status in a second write
    wr(`ECTM_IDX_TIMER_CTRL, 8'h03);
    wr(`ECTM_IDX_TIMER_CTRL, 8'h20);
    repeat (2) @(posedge pclk);
    `CHK(timeout_irq, 1'b0)
    // zero reload wraps without a timeout
    wr(`ECTM_IDX_LOW_RELOAD, 8'h00);
    wr(`ECTM_IDX_TIMER_CTRL, 8'h82);
    repeat (20) @(posedge pclk);
    apb(1'b0, `ECTM_IDX_COUNT, 8'h00, rd, err);
    `CHK((rd[7:0] > 8'hF5) && (rd[7:0] < 8'hFF), 1'b1)
    `CHK(timeout_irq, 1'b0)
    rchk(`ECTM_IDX_TIMER_CTRL, 8'h82);
    wr(`ECTM_IDX_TIMER_CTRL, 8'h00);
    // demodulation: edges 40 cycles (10 ticks) apart, for edge codes 0, 1 and 2
    wr(`ECTM_IDX_LOW_RELOAD, 8'hFF);
    wr(`ECTM_IDX_HIGH_RELOAD, 8'hFF);
    for (int c = 0; c < 3; c++) begin
      // both source pins are covered; the last edge code takes a random one
      init = (c == 2) ? 1'($random(seed)) : 1'(c);
      pin_src <= init;
      wr(`ECTM_IDX_COMMON, {1'b1, init, 2'(c), 4'h0});
      wr(`ECTM_IDX_TIMER_CTRL, 8'h10);
      wr(`ECTM_IDX_TIMER_CTRL, 8'h84);
      for (int e = 0; e < 4; e++) begin
        pin_lvl <= ~pin_lvl;
        apb(1'b0, `ECTM_IDX_COUNT, 8'h00, rd, err);
        if (c == 0 && e == 0) `CHK(rd[7:0], 8'hFF)
        repeat (37) @(posedge pclk);
      end
      apb(1'b0, `ECTM_IDX_LOW_CAP, 8'h00, rd, err);
      if (c != 1) `CHK(near(rd[7:0], c == 0 ? 20 : 30), 1'b1)
      apb(1'b0, `ECTM_IDX_HIGH_CAP, 8'h00, rd, err);
      if (c != 0) `CHK(near(rd[7:0], 20), 1'b1)
      `CHK(capture_irq, 1'b1)
      rchk(`ECTM_IDX_TIMER_CTRL, 8'h94);
      wr(`ECTM_IDX_TIMER_CTRL, 8'h00);
    end
    // capture enable goes back on, so only the cleared status can drop the line
    wr(`ECTM_IDX_TIMER_CTRL, 8'h14);
    repeat (2) @(posedge pclk);
    `CHK(capture_irq, 1'b0)
    rchk(`ECTM_IDX_TIMER_CTRL, 8'h04);
    report_and_stop();
  end
endmodule : tb_top
